//--- hw/method_select.v
// combinational choice of one of six soft interrupt handling methods
`timescale 1ns/1ns
`default_nettype none
module method_select (
  input wire ext_enable_in,
  input wire [1:0] io_privilege_level_in,
  input wire redir_bit_in,
  input wire hw_event_in,
  output reg [5:0] method_out
);
  wire io_privilege_level_top;
  assign io_privilege_level_top = (io_privilege_level_in == 2'h3);
  always @* begin
    method_out = 6'h00;
    if (hw_event_in) begin
      method_out = 6'h01;
    end else if (!ext_enable_in) begin
      method_out = io_privilege_level_top ? 6'h01 : 6'h02;
    end else if (redir_bit_in) begin
      method_out = io_privilege_level_top ? 6'h08 : 6'h04;
    end else begin
      method_out = io_privilege_level_top ? 6'h10 : 6'h20;
    end
  end
endmodule // method_select
`default_nettype wire

//--- hw/stack_push_addr.v
// next stack pointer and linear address of one push
`timescale 1ns/1ns
`default_nettype none
module stack_push_addr (
  input wire [31:0] base_in,
  input wire [31:0] ptr_in,
  input wire wide_in,
  output wire [31:0] new_ptr_out,
  output wire [31:0] addr_out
);
  wire [15:0] low_ptr;
  // a 16-bit stack wraps inside its low half and leaves the upper half alone
  assign low_ptr = ptr_in[15:0] - 16'h0002;
  assign new_ptr_out = wide_in ? (ptr_in - 32'h00000004) : {ptr_in[31:16], low_ptr};
  assign addr_out = wide_in ? (base_in + new_ptr_out) : (base_in + {16'h0000, low_ptr});
endmodule // stack_push_addr
`default_nettype wire

//--- hw/v86_soft_interrupt_dispatch.v
// dispatcher for software interrupts taken in virtual-8086 mode
//
// How it works
// - hardware interrupts always go to gate handlers
// - no extension, level three: gate call
// - gate path pushes segments then interrupted frame
// - gate path clears mode flags, zeroes segments
// - interrupt enable cleared for interrupt gates and level three redirects
// - no extension, level below three: fault
// - extension, low level, bit one: fault
// - extension, low level, bit zero: redirect
// - extension, level three, bit one: gate call
// - bitmap zero redirects, one goes protected
// - redirect pushes flags, cs, ip; loads vector
// - low level redirect image: level three, virtual flag
// - low level redirect clears virtual flag, trap
// - feature register bit one reports extension
// - bitmap byte read below permission map base
// - vector entry read from linear address zero
//
// Design decisions made here: the register addresses and the strobed register port.
`timescale 1ns/1ns
`include "v86_dispatch_regs.vh"
`default_nettype none
module v86_soft_interrupt_dispatch (
  input wire clk_in,
  input wire rst_in,
  input wire ce_in,
  input wire [7:0] reg_addr_in,
  input wire [31:0] reg_wdata_in,
  input wire reg_wr_in,
  input wire reg_rd_in,
  output reg [31:0] reg_rdata_out,
  output wire irq_out,
  input wire swi_start_in,
  input wire hw_event_in,
  input wire [7:0] vector_in,
  input wire gate_is_int_in,
  input wire [15:0] gate_cs_in,
  input wire [31:0] gate_eip_in,
  input wire [31:0] flags_in,
  input wire [15:0] cs_in,
  input wire [31:0] eip_in,
  input wire [15:0] ss_in,
  input wire [31:0] esp_in,
  input wire [31:0] stack_base_in,
  input wire [15:0] ss0_in,
  input wire [31:0] esp0_in,
  input wire [31:0] stack0_base_in,
  input wire [15:0] ds_in,
  input wire [15:0] es_in,
  input wire [15:0] fs_in,
  input wire [15:0] gs_in,
  input wire [31:0] io_map_base_in,
  output reg mem_req_out,
  output reg mem_we_out,
  output reg [1:0] mem_size_out,
  output reg [31:0] mem_addr_out,
  output reg [31:0] mem_wdata_out,
  input wire mem_ack_in,
  input wire [31:0] mem_rdata_in,
  output wire busy_out,
  output reg commit_out,
  output reg fault_out,
  output reg [5:0] method_out,
  output reg [31:0] flags_out,
  output reg [15:0] cs_out,
  output reg [31:0] eip_out,
  output reg [15:0] ss_out,
  output reg [31:0] esp_out,
  output reg [15:0] ds_out,
  output reg [15:0] es_out,
  output reg [15:0] fs_out,
  output reg [15:0] gs_out
);
  localparam S_IDLE = 6'h01;
  localparam S_MAP = 6'h02;
  localparam S_SEL = 6'h04;
  localparam S_PUSH = 6'h08;
  localparam S_VEC = 6'h10;
  localparam S_FIN = 6'h20;

  reg [5:0] state_r;
  reg [31:0] ctrl_r;
  reg [3:0] mask_r;
  reg [3:0] status_r;
  reg [3:0] status_nxt;
  reg [3:0] events;
  reg hw_r;
  reg ext_r;
  reg gate_int_r;
  reg map_bit_r;
  reg [7:0] vector_r;
  reg [31:0] flags_r;
  reg [15:0] cs_r;
  reg [31:0] eip_r;
  reg [15:0] ss_r;
  reg [31:0] esp_r;
  reg [15:0] ds_r;
  reg [15:0] es_r;
  reg [15:0] fs_r;
  reg [15:0] gs_r;
  reg [15:0] gate_cs_r;
  reg [31:0] gate_eip_r;
  reg [15:0] ss0_r;
  reg [31:0] esp0_r;
  reg [31:0] base_r;
  reg [31:0] ptr_r;
  reg [3:0] idx_r;
  reg [15:0] vec_cs_r;
  reg [15:0] vec_ip_r;
  reg [31:0] push_data;
  reg [15:0] redir_image;
  wire [5:0] method_sel;
  wire is_gate;
  wire is_redir;
  wire is_fault;
  wire [31:0] push_ptr;
  wire [31:0] push_addr;
  wire [3:0] last_push;
  wire mem_done;
  wire [7:0] map_byte;

  method_select u_select (
    .ext_enable_in(ext_r),
    .io_privilege_level_in(flags_r[`FLAG_IO_PRIVILEGE_LEVEL_HI:`FLAG_IO_PRIVILEGE_LEVEL_LO]),
    .redir_bit_in(map_bit_r),
    .hw_event_in(hw_r),
    .method_out(method_sel)
  );

  // method register, once loaded, steers the rest of the sequence
  assign is_fault = method_out[1] | method_out[2];
  assign is_gate = method_out[0] | method_out[3];
  assign is_redir = method_out[4] | method_out[5];

  stack_push_addr u_push (
    .base_in(base_r),
    .ptr_in(ptr_r),
    .wide_in(is_gate),
    .new_ptr_out(push_ptr),
    .addr_out(push_addr)
  );

  assign last_push = is_gate ? `GATE_LAST_PUSH : `REDIR_LAST_PUSH;
  assign mem_done = mem_req_out & mem_ack_in;
  assign busy_out = ~state_r[0];
  assign irq_out = |(status_r & mask_r);
  assign map_byte = mem_rdata_in[7:0];

  // flags image of a redirected call; the low level case hides the real level and enable
  always @* begin
    redir_image = flags_r[15:0];
    if (method_out[5]) begin
      redir_image[`FLAG_IO_PRIVILEGE_LEVEL_HI:`FLAG_IO_PRIVILEGE_LEVEL_LO] = 2'h3;
      redir_image[`FLAG_INT] = flags_r[`FLAG_VINT];
    end
  end

  always @* begin
    push_data = 32'h00000000;
    if (is_gate) begin
      case (idx_r)
        4'h0: push_data = {16'h0000, gs_r};
        4'h1: push_data = {16'h0000, fs_r};
        4'h2: push_data = {16'h0000, ds_r};
        4'h3: push_data = {16'h0000, es_r};
        4'h4: push_data = {16'h0000, ss_r};
        4'h5: push_data = esp_r;
        4'h6: push_data = flags_r;
        4'h7: push_data = {16'h0000, cs_r};
        default: push_data = eip_r;
      endcase
    end else begin
      case (idx_r)
        4'h0: push_data = {16'h0000, redir_image};
        4'h1: push_data = {16'h0000, cs_r};
        default: push_data = {16'h0000, eip_r[15:0]};
      endcase
    end
  end

  always @* begin
    events = 4'h0;
    if (state_r[5]) begin
      events[`EV_FAULT] = is_fault;
      events[`EV_GATE] = is_gate & ~hw_r;
      events[`EV_REDIR] = is_redir;
      events[`EV_HW] = hw_r;
    end
  end

  // a new event beats a clear in the same cycle
  always @* begin
    status_nxt = status_r;
    if (reg_wr_in && reg_addr_in == `REG_STATUS) begin
      status_nxt = status_r & ~reg_wdata_in[3:0];
    end
    status_nxt = status_nxt | events;
  end

  always @(posedge clk_in or posedge rst_in) begin
    if (rst_in) begin
      ctrl_r <= `CTRL_RESET;
      mask_r <= `MASK_RESET;
      status_r <= 4'h0;
      reg_rdata_out <= 32'h00000000;
    end else if (ce_in) begin
      status_r <= status_nxt;
      if (reg_wr_in && reg_addr_in == `REG_CONTROL) begin
        ctrl_r <= {31'h00000000, reg_wdata_in[`CTRL_EXT_BIT]};
      end
      if (reg_wr_in && reg_addr_in == `REG_MASK) begin
        mask_r <= reg_wdata_in[3:0];
      end
      reg_rdata_out <= 32'h00000000;
      if (reg_rd_in) begin
        case (reg_addr_in)
          `REG_CONTROL: reg_rdata_out <= ctrl_r;
          `REG_FEATURE: reg_rdata_out <= 32'h00000001 << `FEATURE_EXT_BIT;
          `REG_STATUS: reg_rdata_out <= {28'h0000000, status_r};
          `REG_MASK: reg_rdata_out <= {28'h0000000, mask_r};
          `REG_METHOD: reg_rdata_out <= {24'h000000, busy_out, 1'b0, method_out};
          default: reg_rdata_out <= 32'h00000000;
        endcase
      end
    end
  end

  always @(posedge clk_in or posedge rst_in) begin
    if (rst_in) begin
      state_r <= S_IDLE;
      hw_r <= 1'b0;
      ext_r <= 1'b0;
      gate_int_r <= 1'b0;
      map_bit_r <= 1'b1;
      vector_r <= 8'h00;
      flags_r <= 32'h00000000;
      cs_r <= 16'h0000;
      eip_r <= 32'h00000000;
      ss_r <= 16'h0000;
      esp_r <= 32'h00000000;
      ds_r <= 16'h0000;
      es_r <= 16'h0000;
      fs_r <= 16'h0000;
      gs_r <= 16'h0000;
      gate_cs_r <= 16'h0000;
      gate_eip_r <= 32'h00000000;
      ss0_r <= 16'h0000;
      esp0_r <= 32'h00000000;
      base_r <= 32'h00000000;
      ptr_r <= 32'h00000000;
      idx_r <= 4'h0;
      vec_cs_r <= 16'h0000;
      vec_ip_r <= 16'h0000;
      mem_req_out <= 1'b0;
      mem_we_out <= 1'b0;
      mem_size_out <= `SIZE_BYTE;
      mem_addr_out <= 32'h00000000;
      mem_wdata_out <= 32'h00000000;
      commit_out <= 1'b0;
      fault_out <= 1'b0;
      method_out <= 6'h00;
      flags_out <= 32'h00000000;
      cs_out <= 16'h0000;
      eip_out <= 32'h00000000;
      ss_out <= 16'h0000;
      esp_out <= 32'h00000000;
      ds_out <= 16'h0000;
      es_out <= 16'h0000;
      fs_out <= 16'h0000;
      gs_out <= 16'h0000;
    end else if (ce_in) begin
      commit_out <= 1'b0;
      fault_out <= 1'b0;
      case (state_r)
        S_IDLE: begin
          // a request arriving while busy is ignored; the core waits on busy_out
          if (swi_start_in || hw_event_in) begin
            hw_r <= hw_event_in;
            ext_r <= ctrl_r[`CTRL_EXT_BIT];
            gate_int_r <= gate_is_int_in;
            vector_r <= vector_in;
            flags_r <= flags_in;
            cs_r <= cs_in;
            eip_r <= eip_in;
            ss_r <= ss_in;
            esp_r <= esp_in;
            ds_r <= ds_in;
            es_r <= es_in;
            fs_r <= fs_in;
            gs_r <= gs_in;
            gate_cs_r <= gate_cs_in;
            gate_eip_r <= gate_eip_in;
            ss0_r <= ss0_in;
            esp0_r <= esp0_in;
            base_r <= stack_base_in;
            ptr_r <= esp_in;
            idx_r <= 4'h0;
            map_bit_r <= 1'b1;
            // the bitmap is fetched only when it can change the outcome
            if (ctrl_r[`CTRL_EXT_BIT] && !hw_event_in) begin
              mem_req_out <= 1'b1;
              mem_we_out <= 1'b0;
              mem_size_out <= `SIZE_BYTE;
              mem_addr_out <= io_map_base_in - `MAP_SPAN + {27'h0000000, vector_in[7:3]};
              state_r <= S_MAP;
            end else begin
              state_r <= S_SEL;
            end
          end
        end
        S_MAP: begin
          if (mem_done) begin
            mem_req_out <= 1'b0;
            map_bit_r <= map_byte[vector_r[2:0]];
            state_r <= S_SEL;
          end
        end
        S_SEL: begin
          method_out <= method_sel;
          if (method_sel[1] || method_sel[2]) begin
            state_r <= S_FIN;
          end else begin
            if (method_sel[0] || method_sel[3]) begin
              base_r <= stack0_base_in;
              ptr_r <= esp0_r;
            end
            state_r <= S_PUSH;
          end
        end
        S_PUSH: begin
          if (!mem_req_out) begin
            mem_req_out <= 1'b1;
            mem_we_out <= 1'b1;
            mem_size_out <= is_gate ? `SIZE_WORD : `SIZE_HALF;
            mem_addr_out <= push_addr;
            mem_wdata_out <= push_data;
          end else if (mem_done) begin
            mem_req_out <= 1'b0;
            mem_we_out <= 1'b0;
            ptr_r <= push_ptr;
            idx_r <= idx_r + 4'h1;
            if (idx_r == last_push) begin
              if (is_redir) begin
                mem_req_out <= 1'b1;
                mem_size_out <= `SIZE_WORD;
                mem_addr_out <= `VEC_TABLE_BASE + {22'h000000, vector_r, 2'h0};
                state_r <= S_VEC;
              end else begin
                state_r <= S_FIN;
              end
            end
          end
        end
        S_VEC: begin
          if (mem_done) begin
            mem_req_out <= 1'b0;
            vec_cs_r <= mem_rdata_in[31:16];
            vec_ip_r <= mem_rdata_in[15:0];
            state_r <= S_FIN;
          end
        end
        S_FIN: begin
          state_r <= S_IDLE;
          flags_out <= flags_r;
          cs_out <= cs_r;
          eip_out <= eip_r;
          ss_out <= ss_r;
          esp_out <= esp_r;
          ds_out <= ds_r;
          es_out <= es_r;
          fs_out <= fs_r;
          gs_out <= gs_r;
          if (is_fault) begin
            fault_out <= 1'b1;
          end else begin
            commit_out <= 1'b1;
            esp_out <= ptr_r;
            if (is_gate) begin
              flags_out[`FLAG_VMODE] <= 1'b0;
              flags_out[`FLAG_RESUME] <= 1'b0;
              flags_out[`FLAG_NEST] <= 1'b0;
              flags_out[`FLAG_TRAP] <= 1'b0;
              flags_out[`FLAG_INT] <= gate_int_r ? 1'b0 : flags_r[`FLAG_INT];
              ds_out <= 16'h0000;
              es_out <= 16'h0000;
              fs_out <= 16'h0000;
              gs_out <= 16'h0000;
              ss_out <= ss0_r;
              cs_out <= gate_cs_r;
              eip_out <= gate_eip_r;
            end else begin
              flags_out[`FLAG_TRAP] <= 1'b0;
              if (method_out[5]) begin
                flags_out[`FLAG_VINT] <= 1'b0;
              end else begin
                flags_out[`FLAG_INT] <= 1'b0;
              end
              cs_out <= vec_cs_r;
              eip_out <= {16'h0000, vec_ip_r};
            end
          end
        end
        default: state_r <= S_IDLE;
      endcase
    end
  end
endmodule // v86_soft_interrupt_dispatch
`default_nettype wire

//--- inc/v86_dispatch_regs.vh
// register map, flag positions and sequence counts of the soft interrupt dispatcher
`ifndef V86_DISPATCH_REGS_VH
`define V86_DISPATCH_REGS_VH
`define REG_CONTROL 8'h00
`define REG_FEATURE 8'h04
`define REG_STATUS 8'h08
`define REG_MASK 8'h0c
`define REG_METHOD 8'h10
`define CTRL_EXT_BIT 0
`define CTRL_RESET 32'h00000000
`define FEATURE_EXT_BIT 1
`define MASK_RESET 4'h0
`define EV_FAULT 0
`define EV_GATE 1
`define EV_REDIR 2
`define EV_HW 3
`define EV_WIDTH 4
`define FLAG_TRAP 8
`define FLAG_INT 9
`define FLAG_IO_PRIVILEGE_LEVEL_LO 12
`define FLAG_IO_PRIVILEGE_LEVEL_HI 13
`define FLAG_NEST 14
`define FLAG_RESUME 16
`define FLAG_VMODE 17
`define FLAG_VINT 19
`define MAP_SPAN 32'h00000020
`define VEC_TABLE_BASE 32'h00000000
`define GATE_LAST_PUSH 4'h8
`define REDIR_LAST_PUSH 4'h2
`define SIZE_BYTE 2'h0
`define SIZE_HALF 2'h1
`define SIZE_WORD 2'h2
`endif

//--- tb/v86_dispatch_properties.sv
// port assertions of the soft interrupt dispatcher
`timescale 1ns/1ns
`default_nettype none
`include "v86_dispatch_regs.vh"
module v86_dispatch_properties (
  input wire clk_in,
  input wire rst_in,
  input wire reg_rd_in,
  input wire [7:0] reg_addr_in,
  input wire [31:0] reg_rdata_out,
  input wire hw_event_in,
  input wire busy_out,
  input wire commit_out,
  input wire fault_out,
  input wire [5:0] method_out,
  input wire [31:0] flags_out,
  input wire [31:0] eip_out,
  input wire [15:0] ds_out,
  input wire [15:0] es_out,
  input wire [15:0] fs_out,
  input wire [15:0] gs_out,
  input wire mem_req_out,
  input wire mem_ack_in,
  input wire [31:0] mem_addr_out
);
  default clocking @(posedge clk_in);
  endclocking
  default disable iff (rst_in);
  AST_ONE_METHOD: assert property ((commit_out || fault_out) |-> $onehot(method_out) && !(commit_out && fault_out))
    else $error("answer without a single method");
  AST_ANSWER_IDLE: assert property ((commit_out || fault_out) |-> !busy_out)
    else $error("busy at answer");
  AST_FAULT_KIND: assert property (fault_out |-> method_out == 6'h02 || method_out == 6'h04)
    else $error("fault under a dispatching method");
  AST_GATE_STATE: assert property (commit_out && (method_out[0] || method_out[3]) |->
    flags_out[17:16] == 2'h0 && !flags_out[14] && !flags_out[8] && (ds_out | es_out | fs_out | gs_out) == 16'h0)
    else $error("gate state not cleared");
  AST_REDIR_STATE: assert property (commit_out && (method_out[4] || method_out[5]) |->
    !flags_out[8] && eip_out[31:16] == 16'h0)
    else $error("redirect trap or pointer wrong");
  AST_REDIR_INT: assert property (commit_out && (method_out[4] || method_out[5]) |->
    (method_out[4] ? !flags_out[9] : !flags_out[19]))
    else $error("redirect interrupt flag left set");
  AST_HW_GATE: assert property (hw_event_in && !busy_out |-> ##[1:200] (commit_out && method_out == 6'h01))
    else $error("hardware event not sent to gate");
  AST_FEATURE: assert property (reg_rd_in && reg_addr_in == `REG_FEATURE |=> reg_rdata_out == 32'h2)
    else $error("feature bit missing");
  AST_REQ_HOLD: assert property (mem_req_out && !mem_ack_in |=> mem_req_out && $stable(mem_addr_out))
    else $error("memory request dropped early");
  // covers show both redirect paths and the extension fault path were really reached
  cover property (commit_out && method_out[4]);
  cover property (commit_out && method_out[5]);
  cover property (fault_out && method_out[2]);
endmodule // v86_dispatch_properties
bind v86_soft_interrupt_dispatch v86_dispatch_properties v86_dispatch_properties_inst (.*);
`default_nettype wire

//--- tb/v86_soft_interrupt_dispatch_bench.sv
// self-checking bench of the soft interrupt dispatcher
`timescale 1ns/1ns
`default_nettype none
`include "v86_dispatch_regs.vh"
module v86_soft_interrupt_dispatch_bench;
  logic clk_in = 0, rst_in = 1, ce_in = 1, reg_wr_in = 0, reg_rd_in = 0, swi_start_in = 0, hw_event_in = 0;
  logic gate_is_int_in = 0, mem_ack_in = 0, irq_out, mem_req_out, mem_we_out, busy_out, commit_out, fault_out;
  logic [7:0] reg_addr_in = 8'h0, vector_in = 8'h0, map_byte = 8'h0;
  logic [1:0] mem_size_out;
  logic [5:0] method_out;
  logic [15:0] gate_cs_in = 16'h0008, cs_in = 16'h0c0c, ss_in = 16'h0707, ss0_in = 16'h0010, ds_in = 16'h1111;
  logic [15:0] es_in = 16'h2222, fs_in = 16'h3333, gs_in = 16'h4444, cs_out, ss_out, ds_out, es_out, fs_out, gs_out;
  logic [31:0] reg_wdata_in = 32'h0, gate_eip_in = 32'h0001_2340, flags_in = 32'h0, eip_in = 32'h0005_0102;
  logic [31:0] esp_in = 32'h1234_0002, stack_base_in = 32'h0002_0000, esp0_in = 32'h0000_0800;
  logic [31:0] stack0_base_in = 32'h0010_0000, io_map_base_in = 32'h0000_0100, mem_rdata_in = 32'h0;
  logic [31:0] vec_word = 32'habcd_1234, reg_rdata_out, mem_addr_out, mem_wdata_out, flags_out, eip_out, esp_out, d;
  logic [31:0] wd[$], wa[$], ra[$];
  int err_count = 0, comparisons = 0, n;

  v86_soft_interrupt_dispatch v86_soft_interrupt_dispatch_inst (.*);

  initial forever #10 clk_in = ~clk_in;

  // memory answers one cycle late; idle read data toggles so a stale sample shows
  always @(posedge clk_in) begin
    mem_ack_in <= mem_req_out && !mem_ack_in;
    mem_rdata_in <= !(mem_req_out && !mem_ack_in) ? ~mem_rdata_in :
      mem_size_out == `SIZE_BYTE ? {24'h0, map_byte} : vec_word;
    if (mem_req_out && !mem_ack_in && mem_we_out) begin
      wd.push_back(mem_wdata_out);
      wa.push_back(mem_addr_out);
    end
    if (mem_req_out && !mem_ack_in && !mem_we_out) begin
      ra.push_back(mem_addr_out);
    end
  end

  task automatic chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
    comparisons++;
    if (seen !== exp) begin
      err_count++;
      $display("[FAIL] %s expected %h seen %h", nm, exp, seen);
    end
  endtask

  task automatic wr(input logic [7:0] a, input logic [31:0] v);
    @(posedge clk_in);
    reg_wr_in <= 1;
    reg_addr_in <= a;
    reg_wdata_in <= v;
    @(posedge clk_in);
    reg_wr_in <= 0;
  endtask

  task automatic rd(input logic [7:0] a, output logic [31:0] v);
    @(posedge clk_in);
    reg_rd_in <= 1;
    reg_addr_in <= a;
    @(posedge clk_in);
    reg_rd_in <= 0;
    #1 v = reg_rdata_out;
  endtask

  task automatic go(input logic ext, input logic [31:0] f, input logic [7:0] v, input logic b, input logic hw,
      input logic gi);
    wr(`REG_CONTROL, {31'h0, ext});
    @(posedge clk_in);
    flags_in <= f;
    vector_in <= v;
    gate_is_int_in <= gi;
    // other map bits inverted so a wrong bit index shows
    map_byte <= b ? 8'h01 << v[2:0] : ~(8'h01 << v[2:0]);
    swi_start_in <= !hw;
    hw_event_in <= hw;
    wd.delete();
    wa.delete();
    ra.delete();
    @(posedge clk_in);
    swi_start_in <= 0;
    hw_event_in <= 0;
    n = 0;
    while (!(commit_out || fault_out) && n < 300) begin
      @(posedge clk_in);
      #1 n++;
    end
    chk("answer", n < 300, 1);
  endtask

  task automatic gate(input logic ext, input logic [31:0] f, input logic gi, input logic [5:0] m, input logic hw);
    logic [31:0] e[9];
    e = '{{16'h0, gs_in}, {16'h0, fs_in}, {16'h0, ds_in}, {16'h0, es_in}, {16'h0, ss_in}, esp_in, f,
      {16'h0, cs_in}, eip_in};
    go(ext, f, 8'h42, !hw, hw, gi);
    chk("method", method_out, m);
    chk("pushes", wd.size(), 9);
    for (int i = 0; i < 9; i++) begin
      chk("push data", wd[i], e[i]);
      chk("push addr", wa[i], 32'h0010_0800 - 4 * (i + 1));
    end
    chk("flags", flags_out, f & ~32'h0003_4100 & ~(gi ? 32'h200 : 32'h0));
    chk("segs", ds_out | es_out | fs_out | gs_out, 0);
    chk("cs", cs_out, gate_cs_in);
    chk("eip", eip_out, gate_eip_in);
    chk("ss", ss_out, ss0_in);
    chk("esp", esp_out, esp0_in - 36);
  endtask

  task automatic redir(input logic [31:0] f, input logic [15:0] img, input logic [31:0] fo, input logic [5:0] m);
    logic [15:0] sp;
    logic [15:0] e[3];
    e = '{img, cs_in, eip_in[15:0]};
    sp = esp_in[15:0];
    go(1, f, 8'h21, 0, 0, 0);
    chk("method", method_out, m);
    chk("pushes", wd.size(), 3);
    for (int i = 0; i < 3; i++) begin
      // stack pointer starts at 2 so the pushes wrap in the low half
      sp = sp - 16'h2;
      chk("push data", wd[i][15:0], e[i]);
      chk("push addr", wa[i], 32'h0002_0000 + {16'h0, sp});
    end
    chk("map addr", ra[0], 32'h0000_00e4);
    chk("vec addr", ra[1], 32'h0000_0084);
    chk("cs", cs_out, vec_word[31:16]);
    chk("eip", eip_out, {16'h0, vec_word[15:0]});
    chk("flags", flags_out, fo);
    chk("esp", esp_out, {esp_in[31:16], sp});
  endtask

  task automatic test_regs;
    rd(`REG_FEATURE, d);
    chk("feature", d, 32'h2);
    wr(`REG_FEATURE, 32'h0);
    rd(`REG_FEATURE, d);
    chk("feature ro", d, 32'h2);
    rd(`REG_CONTROL, d);
    chk("control", d, `CTRL_RESET);
    // a write while the clock enable is low must be lost
    @(posedge clk_in);
    ce_in <= 0;
    wr(`REG_MASK, 32'h5);
    ce_in <= 1;
    rd(`REG_MASK, d);
    chk("mask", d, 32'h0);
    rd(8'h20, d);
    chk("unmapped", d, 32'h0);
    $display("test regs done");
  endtask

  task automatic test_fault;
    go(0, 32'h000b_5102, 8'h0d, 1, 0, 0);
    chk("fault m2", fault_out, 1);
    // take edge not counted: sel, then the fin edge that raises the pulse
    chk("latency", n, 2);
    chk("method m2", method_out, 6'h02);
    chk("flags kept", flags_out, 32'h000b_5102);
    chk("no writes", wd.size(), 0);
    go(1, 32'h000b_5102, 8'h0d, 1, 0, 0);
    chk("fault m3", fault_out, 1);
    chk("method m3", method_out, 6'h04);
    chk("map addr", ra[0], 32'h0000_00e1);
    $display("test fault done");
  endtask

  task automatic test_gate;
    gate(0, 32'h0003_7302, 1, 6'h01, 0);
    gate(1, 32'h0003_7302, 0, 6'h08, 0);
    $display("test gate done");
  endtask

  task automatic test_redir;
    redir(32'h0003_7302, 16'h7302, 32'h0003_7002, 6'h10);
    redir(32'h000b_5102, 16'h7302, 32'h0003_5002, 6'h20);
    $display("test redir done");
  endtask

  task automatic test_hw;
    wr(`REG_MASK, 32'h8);
    gate(1, 32'h0003_7302, 1, 6'h01, 1);
    chk("irq hw", irq_out, 1);
    rd(`REG_STATUS, d);
    chk("status", d, 32'hf);
    wr(`REG_STATUS, 32'h8);
    #1 chk("irq clear", irq_out, 0);
    wr(`REG_MASK, 32'h7);
    #1 chk("irq mask", irq_out, 1);
    wr(`REG_STATUS, 32'h7);
    #1 chk("irq off", irq_out, 0);
    $display("test hw done");
  endtask

  task automatic test_done;
    $display("comparisons %0d mismatches %0d", comparisons, err_count);
    if (err_count == 0 && comparisons > 0) begin
      $display("Run complete: PASS");
    end else begin
      $display("Run complete: FAIL");
    end
    $finish;
  endtask

  initial begin
    #100000;
    err_count++;
    test_done();
  end

  initial begin
    repeat (12) @(posedge clk_in);
    rst_in <= 0;
    test_regs();
    test_fault();
    test_gate();
    test_redir();
    test_hw();
    test_done();
  end
endmodule // v86_soft_interrupt_dispatch_bench
`default_nettype wire
